// file: shared/lead_off_pkg.sv
// Constants and types for the lead-off detection control block.
// Assumes a single clock domain and a 32-bit serial frame from the host.
package lead_off_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int          FRAME_BITS  = 32;
  localparam int          ADDR_BITS   = 7;
  localparam int          DATA_BITS   = 24;
  localparam int          HEAD_BITS   = 8;      // Write flag plus address
  localparam logic [6:0]  ADDR_NOP    = 7'h00;
  localparam logic [6:0]  ADDR_MAIN   = 7'h01;  // Main control, holds soft reset
  localparam logic [6:0]  ADDR_LOFF   = 7'h02;  // Lead-off control

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          SOFT_RESET_POS = 0;
  localparam int          PHASE_HI       = 23;
  localparam int          PHASE_LO       = 18;
  localparam int          AC_EN_HI       = 17;
  localparam int          AC_EN_LO       = 12;
  localparam int          AC_LVL_HI      = 8;
  localparam int          AC_LVL_LO      = 7;
  localparam int          DC_LVL_HI      = 4;
  localparam int          DC_LVL_LO      = 2;
  localparam int          AC_SEL_POS     = 1;
  localparam int          DETECT_EN_POS  = 0;
  localparam int          CE_INDEX       = 0;   // Common electrode is the lowest bit

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0]  PHASE_RST   = 6'h00;
  localparam logic [5:0]  AC_EN_RST   = 6'h00;
  localparam logic [1:0]  AC_LVL_RST  = 2'h0;
  localparam logic [2:0]  DC_LVL_RST  = 3'h0;
  localparam logic        AC_SEL_RST  = 1'b0;
  localparam logic        DET_EN_RST  = 1'b0;

  // Electrode order in every 6-bit vector: LA, LL, RA, V1, V2, CE (MSB first)
  typedef struct packed {
    logic [5:0] ac_phase;
    logic [5:0] ac_detect_en;
    logic [1:0] ac_excitation_level;
    logic [2:0] dc_excitation_level;
    logic       ac_method_select;
    logic       detach_detect_enable;
  } lead_off_ctl_t;

  localparam lead_off_ctl_t LOFF_RST = '{PHASE_RST, AC_EN_RST, AC_LVL_RST, DC_LVL_RST,
                                         AC_SEL_RST, DET_EN_RST};

endpackage

// file: rtl/lead_off_detect_control.sv
// Lead-off detection control register with its serial access port.
// Assumes serial pins asynchronous to MCLK and SCLK well below MCLK/4.
// Summary of operation
// - Writing one to main control bit 0 returns every register to reset.
// - The soft reset bit clears itself; software never writes zero to it.
// - Bits 23..18 set each electrode's ac drive phase: zero in phase, one inverted.
// - Bits 17..12 individually enable ac detection per electrode, common included.
// - Effective ac enable is global ac select OR the individual enable.
// - Global ac select covers the five signal electrodes, not the common one.
// - Bits 8..7 choose ac current 12.5/25/50/100 nA rms, reset 00.
// - Bits 4..2 choose dc current 0..70 nA, only while ac select is zero.
// - With detection on, ac select zero means dc, one means ac detection.
// - Ac select is ignored while the master enable is zero.
// - Bit 0 master enable: zero disables all detection, reset zero.
// - An enabled calibration DAC forces ac detection off.
`timescale 1ns/1ps

module lead_off_detect_control
  import lead_off_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SDI,
  input  wire logic       CAL_DAC_EN,
  output logic            SDO,
  output logic            SDO_OE,
  output logic [5:0]      AC_DETECT_EN,
  output logic [5:0]      AC_PHASE,
  output logic [1:0]      AC_LEVEL,
  output logic            DC_DETECT_EN,
  output logic [2:0]      DC_LEVEL,
  output logic            SOFT_RESET_PENDING
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       sclk_prev;

  // Two flops per pin; only the second stage feeds logic
  // Reset to the idle levels (SCLK low, CS_N high) so no false edge follows reset
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      sync1     <= 3'h3;
      sync2     <= 3'h3;
      sclk_prev <= 1'b0;
    end else begin
      sync1     <= {SCLK, CS_N, SDI};
      sync2     <= sync1;
      sclk_prev <= sync2[2];
    end
  end

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_s    = sync2[2];
  assign cs_n_s    = sync2[1];
  assign sdi_s     = sync2[0];
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev;

  // ****************************************
  // Frame receiver
  // ****************************************
  logic [31:0] rx;
  logic [5:0]  bit_cnt;
  logic [23:0] tx;
  logic        is_read;

  // A frame cut short by CS_N is dropped: the counter restarts at zero
  // Count and shift on rising SCLK; deselect aborts a partial frame
  always_ff @(posedge MCLK) begin
    if (!RSTN || cs_n_s) begin
      rx      <= 32'h0000_0000;
      bit_cnt <= 6'h00;
    end else if (sclk_rise) begin
      rx      <= {rx[30:0], sdi_s};
      bit_cnt <= (bit_cnt == 6'(FRAME_BITS)) ? 6'h01 : bit_cnt + 6'h01;
    end
  end

  // Counter holds the bits already taken, so the last bit arrives at count 31
  logic frame_done;
  logic head_done;
  assign frame_done = sclk_rise && (bit_cnt == 6'(FRAME_BITS - 1));
  assign head_done  = sclk_rise && (bit_cnt == 6'(HEAD_BITS - 1));

  // Write flag and address are the oldest eight bits once the frame is complete
  logic [6:0]  head_addr;
  logic        write_main;
  logic        write_loff;
  logic        frame_end;
  logic [23:0] wdata;
  assign head_addr  = {rx[5:0], sdi_s};    // Address ends with the eighth bit
  assign wdata      = {rx[22:0], sdi_s};
  assign frame_end  = frame_done;
  assign write_main = frame_done && rx[31 - 1] && (rx[29:23] == ADDR_MAIN);
  assign write_loff = frame_done && rx[31 - 1] && (rx[29:23] == ADDR_LOFF);

  // ****************************************
  // Register storage
  // ****************************************
  lead_off_ctl_t loff;
  logic          soft_reset_bit;

  // Reserved positions are never stored, so writes to them vanish
  // Soft reset wipes the fields at once; a write in the same frame cannot race it
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      loff <= LOFF_RST;
    end else if (write_main && wdata[SOFT_RESET_POS]) begin
      loff <= LOFF_RST;
    end else if (write_loff) begin
      loff.ac_phase             <= wdata[PHASE_HI:PHASE_LO];
      loff.ac_detect_en         <= wdata[AC_EN_HI:AC_EN_LO];
      loff.ac_excitation_level  <= wdata[AC_LVL_HI:AC_LVL_LO];
      loff.dc_excitation_level  <= wdata[DC_LVL_HI:DC_LVL_LO];
      loff.ac_method_select     <= wdata[AC_SEL_POS];
      loff.detach_detect_enable <= wdata[DETECT_EN_POS];
    end
  end

  // Bit holds until the next whole frame, which the host sends as a no-op
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      soft_reset_bit <= 1'b0;
    end else if (write_main && wdata[SOFT_RESET_POS]) begin
      soft_reset_bit <= 1'b1;
    end else if (frame_end) begin
      soft_reset_bit <= 1'b0;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Reserved and unmapped bits stay zero, so nothing stored leaks onto SDO
  function automatic logic [23:0] read_word(input logic [6:0] a);
    logic [23:0] w;
    w = 24'h00_0000;
    if (a == ADDR_LOFF) begin
      w[PHASE_HI:PHASE_LO]   = loff.ac_phase;
      w[AC_EN_HI:AC_EN_LO]   = loff.ac_detect_en;
      w[AC_LVL_HI:AC_LVL_LO] = loff.ac_excitation_level;
      w[DC_LVL_HI:DC_LVL_LO] = loff.dc_excitation_level;
      w[AC_SEL_POS]          = loff.ac_method_select;
      w[DETECT_EN_POS]       = loff.detach_detect_enable;
    end else if (a == ADDR_MAIN) begin
      w[SOFT_RESET_POS] = soft_reset_bit;
    end
    return w;
  endfunction

  // Read data loads after the header and leaves MSB first on falling SCLK
  always_ff @(posedge MCLK) begin
    if (!RSTN || cs_n_s) begin
      tx      <= 24'h00_0000;
      is_read <= 1'b0;
    end else if (head_done) begin
      tx      <= read_word(head_addr);
      is_read <= !rx[6];
    end else if (sclk_fall && is_read && bit_cnt > 6'(HEAD_BITS)) begin
      tx      <= {tx[22:0], 1'b0};
    end
  end

  // Enable follows the synchronised select, so it drops a few MCLK after CS_N rises
  // Pin driven only during the data phase of a read frame
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      SDO    <= 1'b0;
      SDO_OE <= 1'b0;
    end else begin
      SDO    <= tx[23];
      SDO_OE <= is_read && !cs_n_s && (bit_cnt >= 6'(HEAD_BITS));
    end
  end

  // ****************************************
  // Detection controls
  // ****************************************
  logic [5:0] global_ac;
  logic       detect_on;
  logic       ac_mode;
  // Master enable gates both methods; ac select alone does nothing
  assign detect_on = loff.detach_detect_enable;
  assign ac_mode   = detect_on && loff.ac_method_select;
  // Global select reaches the five signal electrodes only
  assign global_ac = {{5{ac_mode}}, 1'b0};

  // Trade-off: DC_LEVEL shows zero while dc is off, yet the stored code survives
  // Calibration DAC overrides every ac enable
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      AC_DETECT_EN       <= 6'h00;
      AC_PHASE           <= PHASE_RST;
      AC_LEVEL           <= AC_LVL_RST;
      DC_DETECT_EN       <= 1'b0;
      DC_LEVEL           <= DC_LVL_RST;
      SOFT_RESET_PENDING <= 1'b0;
    end else begin
      AC_DETECT_EN       <= (CAL_DAC_EN || !detect_on) ? 6'h00 :
                            (global_ac | loff.ac_detect_en);
      AC_PHASE           <= loff.ac_phase;
      AC_LEVEL           <= loff.ac_excitation_level;
      DC_DETECT_EN       <= detect_on && !loff.ac_method_select;
      DC_LEVEL           <= (detect_on && !loff.ac_method_select) ?
                            loff.dc_excitation_level : DC_LVL_RST;
      SOFT_RESET_PENDING <= soft_reset_bit;
    end
  end

endmodule

// file: tb/lead_off_asserts.sv
// Checker for the lead-off control block, watching its top ports only.
// Assumes one clock MCLK and synchronous active-low RSTN.
`timescale 1ns/1ps
module lead_off_asserts (
  input wire logic       MCLK,
  input wire logic       RSTN,
  input wire logic       CS_N,
  input wire logic       CAL_DAC_EN,
  input wire logic [5:0] AC_DETECT_EN,
  input wire logic [5:0] AC_PHASE,
  input wire logic [1:0] AC_LEVEL,
  input wire logic       DC_DETECT_EN,
  input wire logic [2:0] DC_LEVEL,
  input wire logic       SOFT_RESET_PENDING
);
  // ****
  // Properties
  // ****
  // Eight idle cycles on CS_N leave no write still landing
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  AST_CAL_OFF: assert property (CAL_DAC_EN |=> AC_DETECT_EN == 6'h00)
    else $error("ac enable while calibration on");
  AST_DC_LVL: assert property (!DC_DETECT_EN |-> DC_LEVEL == 3'h0)
    else $error("dc level while dc off");
  AST_GLOBAL_FIVE: assert property ((!DC_DETECT_EN && AC_DETECT_EN != 6'h00)
    |-> AC_DETECT_EN[5:1] == 5'h1F) else $error("global ac missed an electrode");
  AST_PEND_CLEAR: assert property (SOFT_RESET_PENDING && $past(SOFT_RESET_PENDING)
    |-> AC_DETECT_EN == 6'h00 && !DC_DETECT_EN) else $error("detection on in soft reset");
  AST_SELF_CLEAR: assert property ($rose(SOFT_RESET_PENDING)
    |-> SOFT_RESET_PENDING[*8] ##[1:900] !SOFT_RESET_PENDING) else $error("reset bit stuck");
  AST_PHASE_QUIET: assert property (CS_N[*8] |-> $stable(AC_PHASE))
    else $error("phase moved without a frame");
  AST_LEVEL_QUIET: assert property (CS_N[*8] |-> $stable(AC_LEVEL) && $stable(DC_LEVEL))
    else $error("level moved without a frame");
  AST_EN_QUIET: assert property (CS_N[*8] ##0 $stable(CAL_DAC_EN)
    |=> $stable(AC_DETECT_EN) && $stable(DC_DETECT_EN)) else $error("enable moved idle");
endmodule

bind lead_off_detect_control lead_off_asserts lead_off_asserts_inst (
  .MCLK(MCLK), .RSTN(RSTN), .CS_N(CS_N), .CAL_DAC_EN(CAL_DAC_EN),
  .AC_DETECT_EN(AC_DETECT_EN), .AC_PHASE(AC_PHASE), .AC_LEVEL(AC_LEVEL),
  .DC_DETECT_EN(DC_DETECT_EN), .DC_LEVEL(DC_LEVEL), .SOFT_RESET_PENDING(SOFT_RESET_PENDING));

// file: tb/tb_lead_off_detect_control.sv
// Testbench for the lead-off control block driven through serial frames.
// Assumes read data shows on SDO within the frame and writes land before CS_N rises.
`timescale 1ns/1ps
module tb_lead_off_detect_control
  import lead_off_pkg::*;
;
  logic        MCLK, RSTN, SCLK, CS_N, SDI, CAL_DAC_EN, SDO, SDO_OE;
  logic        DC_DETECT_EN, SOFT_RESET_PENDING;
  logic [5:0]  AC_DETECT_EN, AC_PHASE;
  logic [1:0]  AC_LEVEL;
  logic [2:0]  DC_LEVEL;
  logic [23:0] rd;
  logic        oe_mid;
  logic [23:0] wdat [6];
  logic        cal [6];
  int          error_cnt = 0;
  int          tests_run = 0;

  lead_off_detect_control lead_off_detect_control_inst (
    .MCLK(MCLK), .RSTN(RSTN), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .CAL_DAC_EN(CAL_DAC_EN),
    .SDO(SDO), .SDO_OE(SDO_OE), .AC_DETECT_EN(AC_DETECT_EN), .AC_PHASE(AC_PHASE),
    .AC_LEVEL(AC_LEVEL), .DC_DETECT_EN(DC_DETECT_EN), .DC_LEVEL(DC_LEVEL),
    .SOFT_RESET_PENDING(SOFT_RESET_PENDING));

  // 125 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // ****
  // Tasks
  // ****
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One 32-bit frame; half SCLK period of 6 MCLK keeps the synchronisers happy
  task automatic xfer(input logic we, input logic [6:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {we, a, d};
    q = 24'h0;
    CS_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    for (int i = 31; i >= 0; i--) begin
      SDI <= f[i];
      SCLK <= 1'b0;
      repeat (6) @(posedge MCLK);
      if (i < 24) q[i] = SDO;
      if (i == 12) oe_mid = SDO_OE;
      SCLK <= 1'b1;
      repeat (6) @(posedge MCLK);
    end
    SCLK <= 1'b0;
    repeat (6) @(posedge MCLK);
    CS_N <= 1'b1;
    repeat (10) @(posedge MCLK);
  endtask

  // Expected pins worked out from the written word and calibration state
  task automatic chk_pins(input logic [23:0] d, input logic c);
    logic dc;
    dc = d[0] & ~d[1];
    chk("ac enable", {18'h0, d[0] ? (d[17:12] | {{5{d[1]}}, 1'b0}) & {6{~c}} : 6'h00},
        {18'h0, AC_DETECT_EN});
    chk("phase", {18'h0, d[23:18]}, {18'h0, AC_PHASE});
    chk("ac level", {22'h0, d[8:7]}, {22'h0, AC_LEVEL});
    chk("dc enable", {23'h0, dc}, {23'h0, DC_DETECT_EN});
    chk("dc level", {21'h0, dc ? d[4:2] : 3'h0}, {21'h0, DC_LEVEL});
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    RSTN = 1'b0;
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
    CAL_DAC_EN = 1'b0;
    wdat = '{24'hFFFFFF, 24'h03F002, 24'hA80083, 24'h001115, 24'h00119F, 24'h03F01D};
    cal = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk_pins(24'h0, 1'b0);
    xfer(1'b0, ADDR_LOFF, 24'h0, rd);
    chk("reset value", 24'h0, rd);
    chk("read drive", 24'h1, {23'h0, oe_mid});
    chk("drive released", 24'h0, {23'h0, SDO_OE});
    for (int k = 0; k < 6; k++) begin
      CAL_DAC_EN <= cal[k];
      xfer(1'b1, ADDR_LOFF, wdat[k], rd);
      chk("write drive", 24'h0, {23'h0, oe_mid});
      xfer(1'b0, ADDR_LOFF, 24'h0, rd);
      chk("readback", wdat[k] & 24'hFFF19F, rd);
      chk_pins(wdat[k], cal[k]);
    end
    xfer(1'b1, ADDR_MAIN, 24'h000001, rd);
    chk("pending", 24'h1, {23'h0, SOFT_RESET_PENDING});
    chk_pins(24'h0, 1'b0);
    xfer(1'b0, ADDR_NOP, 24'h0, rd);
    chk("pending off", 24'h0, {23'h0, SOFT_RESET_PENDING});
    xfer(1'b0, ADDR_LOFF, 24'h0, rd);
    chk("after soft reset", 24'h0, rd);
    xfer(1'b1, 7'h05, 24'hABCDEF, rd);
    xfer(1'b0, 7'h05, 24'h0, rd);
    chk("unmapped", 24'h0, rd);
    xfer(1'b1, ADDR_LOFF, 24'hFFFFFF, rd);
    chk_pins(24'hFFFFFF, 1'b0);
    RSTN <= 1'b0;
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk_pins(24'h0, 1'b0);
    xfer(1'b0, ADDR_LOFF, 24'h0, rd);
    chk("hard reset", 24'h0, rd);
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge MCLK);
    error_cnt++;
    finish_test();
  end
endmodule
